// *** pkg/qp_map.svh ***
`ifndef QP_MAP_SVH
`define QP_MAP_SVH
`define QP_OP_GANG_P2W  4'h1
`define QP_OP_INCDEC    4'h2
`define QP_OP_GANG_W2P  4'h8
`define QP_OP_RD_WIPER  4'h9
`define QP_OP_WR_WIPER  4'hA
`define QP_OP_RD_PRESET 4'hB
`define QP_OP_WR_PRESET 4'hC
`define QP_OP_XFR_P2W   4'hD
`define QP_OP_XFR_W2P   4'hE
`define QP_WIPER_MAX    6'h3F
`define QP_PRESET_INIT  6'h20
`define QP_CLK_MHZ      100
`define QP_NV_PROG_MS   5
`define QP_NV_PROG_CYC  (`QP_NV_PROG_MS * `QP_CLK_MHZ * 1000)
`define QP_PWRUP_MS     1
`define QP_PWRUP_CYC    (`QP_PWRUP_MS * `QP_CLK_MHZ * 1000)
`define QP_SCL_MIN_NS   2500
`define QP_QTR_CYC      ((`QP_SCL_MIN_NS * `QP_CLK_MHZ / 1000 + 3) / 4)
`endif

// *** pkg/qp_pkg.sv ***
package qp_pkg;
	typedef logic [5:0] qp_wiper_t;
	typedef enum logic [2:0] {
		QP_D_IDLE   = 3'h0,
		QP_D_ADDR   = 3'h1,
		QP_D_INSTR  = 3'h2,
		QP_D_DATA   = 3'h3,
		QP_D_READ   = 3'h4,
		QP_D_INCDEC = 3'h5
	} qp_dev_st_e;
	typedef enum logic [2:0] {
		QP_H_IDLE  = 3'h0,
		QP_H_START = 3'h1,
		QP_H_BIT   = 3'h2,
		QP_H_STEP  = 3'h3,
		QP_H_STOP  = 3'h4
	} qp_host_st_e;
endpackage : qp_pkg

// *** pkg/qp_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface qp_if;
	logic scl;
	logic host_sda_oe;
	logic dev_sda_oe;
	logic sda;
	// open-drain wire with pull-up: low while either end drives
	assign sda = ~(host_sda_oe | dev_sda_oe);
	modport host (output scl, output host_sda_oe, input sda);
	modport dev  (input scl, output dev_sda_oe, input sda);
endinterface : qp_if
`default_nettype wire

// *** verilog/qp_host.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "qp_map.svh"
module qp_host #(
	parameter int PWRUP_CYC = `QP_PWRUP_CYC,
	parameter int QTR_CYC   = `QP_QTR_CYC
) (
	input  wire logic       mclk,
	input  wire logic       rst,
	qp_if.host              bus,
	input  wire logic       req,
	input  wire logic [7:0] addr_byte,
	input  wire logic [7:0] instr_byte,
	input  wire logic [7:0] wr_byte,
	input  wire logic [1:0] nbytes,
	input  wire logic       rd_mode,
	input  wire logic [5:0] step_cnt,
	input  wire logic       step_up,
	output logic            ready,
	output logic            done,
	output logic            acked,
	output logic [7:0]      rd_byte
);
	import qp_pkg::*;
	localparam int PW = $clog2(PWRUP_CYC + 1);
	localparam int QW = $clog2(QTR_CYC + 1);
	qp_host_st_e     st_r;
	logic [PW-1:0]   pwr_cnt_r;
	logic [QW-1:0]   qtr_cnt_r;
	logic [1:0]      q_r;
	logic [3:0]      bit_r;
	logic [1:0]      byte_r;
	logic [7:0]      a_r;
	logic [7:0]      i_r;
	logic [7:0]      w_r;
	logic [1:0]      n_r;
	logic            rdm_r;
	logic [5:0]      stp_r;
	logic            up_r;
	logic [7:0]      rx_r;
	logic            scl_r;
	logic            oe_r;
	logic            sda_m;
	logic            sda_q;
	wire             pwr_ok   = (pwr_cnt_r == PW'(PWRUP_CYC));
	wire             tick     = (qtr_cnt_r == QW'(QTR_CYC - 1));
	wire             rd_byte3 = rdm_r & (byte_r == 2'd2);
	wire [7:0]       cur_tx   = (byte_r == 2'd0) ? a_r : (byte_r == 2'd1) ? i_r : w_r;
	wire             is_step  = (i_r[7:4] == `QP_OP_INCDEC);
	wire             last     = ({1'b0, byte_r} + 3'd1 >= {1'b0, n_r});
	assign bus.scl         = scl_r;
	assign bus.host_sda_oe = oe_r;
	assign ready           = (st_r == QP_H_IDLE) & pwr_ok;
	always_ff @(posedge mclk) begin
		if (rst) begin
			sda_m <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			sda_m <= bus.sda;
			sda_q <= sda_m;
		end
	end
	// power-up hold-off before the first transfer
	always_ff @(posedge mclk) begin
		if (rst)
			pwr_cnt_r <= '0;
		else if (!pwr_ok)
			pwr_cnt_r <= pwr_cnt_r + PW'(1);
	end
	always_ff @(posedge mclk) begin
		if (rst || st_r == QP_H_IDLE || tick)
			qtr_cnt_r <= '0;
		else
			qtr_cnt_r <= qtr_cnt_r + QW'(1);
	end
	always_ff @(posedge mclk) begin
		if (rst) begin
			st_r <= QP_H_IDLE; scl_r <= 1'b1; oe_r <= 1'b0; q_r <= 2'd0; bit_r <= 4'd0; byte_r <= 2'd0;
			a_r <= 8'h00; i_r <= 8'h00; w_r <= 8'h00; n_r <= 2'd0; rdm_r <= 1'b0; stp_r <= 6'h00;
			up_r <= 1'b0; rx_r <= 8'h00; done <= 1'b0; acked <= 1'b0; rd_byte <= 8'h00;
		end else begin
			done <= 1'b0;
			if (st_r == QP_H_IDLE) begin
				if (req && pwr_ok) begin
					st_r <= QP_H_START; q_r <= 2'd0; bit_r <= 4'd0; byte_r <= 2'd0; acked <= 1'b1;
					a_r <= addr_byte; i_r <= instr_byte; w_r <= wr_byte; n_r <= nbytes;
					rdm_r <= rd_mode; stp_r <= step_cnt; up_r <= step_up;
				end
			end else if (tick) begin
				q_r <= q_r + 2'd1;
				unique case (st_r)
					QP_H_START: begin
						if (q_r == 2'd1)
							oe_r <= 1'b1;
						if (q_r == 2'd3) begin
							scl_r <= 1'b0;
							st_r <= QP_H_BIT;
						end
					end
					QP_H_BIT: begin
						if (q_r == 2'd0)
							oe_r <= (bit_r < 4'd8) & ~rd_byte3 & ~cur_tx[3'(4'd7 - bit_r)];
						if (q_r == 2'd1)
							scl_r <= 1'b1;
						if (q_r == 2'd2 && bit_r < 4'd8)
							rx_r <= {rx_r[6:0], sda_q};
						if (q_r == 2'd2 && bit_r == 4'd8 && !rd_byte3 && sda_q)
							acked <= 1'b0;
						if (q_r == 2'd3) begin
							scl_r <= 1'b0;
							bit_r <= (bit_r == 4'd8) ? 4'd0 : bit_r + 4'd1;
							if (bit_r == 4'd8) begin
								byte_r <= byte_r + 2'd1;
								if (rd_byte3)
									rd_byte <= rx_r;
								// after its instruction byte, a step command with a nonzero count goes on to its pulses whatever the byte count says
								if (!acked)
									st_r <= QP_H_STOP;
								else if (byte_r == 2'd1 && is_step)
									st_r <= (stp_r == 6'h00) ? QP_H_STOP : QP_H_STEP;
								else if (last)
									st_r <= QP_H_STOP;
							end
						end
					end
					QP_H_STEP: begin
						if (q_r == 2'd0)
							oe_r <= ~up_r;
						if (q_r == 2'd1)
							scl_r <= 1'b1;
						if (q_r == 2'd3) begin
							scl_r <= 1'b0;
							stp_r <= stp_r - 6'h01;
							if (stp_r == 6'h01)
								st_r <= QP_H_STOP;
						end
					end
					QP_H_STOP: begin
						if (q_r == 2'd0)
							oe_r <= 1'b1;
						if (q_r == 2'd1)
							scl_r <= 1'b1;
						if (q_r == 2'd2)
							oe_r <= 1'b0;
						if (q_r == 2'd3) begin
							done <= 1'b1;
							st_r <= QP_H_IDLE;
						end
					end
					default: st_r <= QP_H_IDLE;
				endcase
			end
		end
	end
endmodule : qp_host
`default_nettype wire

// *** verilog/qp_dev.sv ***
// How it works
// - master waits 1 ms after power-up
// - during 5 ms programming, ignore address, release SDA
// - SDA fall with SCL high is START
// - SDA rise with SCL high is STOP
// - SDA change while SCL high is condition
// - master starts only on idle bus, clocks
// - address: type code plus strap match, else silent
// - receiver acknowledges in ninth clock
// - acknowledge instruction and one data byte once selected; preset data only while protect high
// - read: shift 8, sample master ack, continue
// - write sequence; program preset at STOP only
// - instruction: opcode, preset select, pot select
// - preset select picks preset by binary value
// - address poll NACKed while busy, ACKed after
// - write-protect low: NACK preset data, no program
// - protect before cycle blocks; after, no effect
// - 6-bit wiper decoded to one of 64 taps
// - wiper: host write, preset transfer, step
// - power-up loads wiper from preset zero
// - step per SCL high pulse, SDA sets direction
`timescale 1ns/1ps
`default_nettype none
`include "qp_map.svh"
module qp_dev #(
	parameter logic [3:0] TYPE_CODE   = 4'hA, // arbitrary device-type code
	parameter int         NV_PROG_CYC = `QP_NV_PROG_CYC
) (
	input  wire logic                  mclk,
	input  wire logic                  rst,
	qp_if.dev                          bus,
	input  wire logic [3:0]            address_strap_pins,
	input  wire logic                  wp_n,
	output qp_pkg::qp_wiper_t [3:0]    wiper_position_reg,
	output logic [3:0][63:0]           tap_sel,
	output logic                       nv_busy
);
	import qp_pkg::*;
	localparam int CW = $clog2(NV_PROG_CYC + 1);
	logic                  scl_m;
	logic                  scl_q;
	logic                  scl_p;
	logic                  sda_m;
	logic                  sda_q;
	logic                  sda_p;
	logic [3:0]            strap_m;
	logic [3:0]            strap_q;
	logic                  wp_m;
	logic                  wp_q;
	qp_dev_st_e            st_r;
	logic [3:0]            cnt_r;
	logic [7:0]            sh_r;
	logic [7:0]            tx_r;
	logic                  drv_r;
	logic                  mack_r;
	logic [3:0]            op_r;
	logic [1:0]            psel_r;
	logic [1:0]            pot_r;
	logic                  pend_r;
	logic                  pend_wip_r;
	logic                  pend_gang_r;
	logic [1:0]            pend_sel_r;
	logic [1:0]            pend_pot_r;
	qp_wiper_t             pend_val_r;
	logic                  busy_r;
	logic [CW-1:0]         prog_cnt_r;
	logic                  boot_r;
	qp_wiper_t [3:0]       wiper_r;
	qp_wiper_t [3:0][3:0]  preset_r;

	// line conditions seen only through the synchronisers
	wire scl_rise  = scl_q & ~scl_p;
	wire scl_fall  = ~scl_q & scl_p;
	wire start_det = scl_q & scl_p & sda_p & ~sda_q;
	wire stop_det  = scl_q & scl_p & ~sda_p & sda_q;
	wire bus_cond  = start_det | stop_det;
	wire rx_state  = (st_r == QP_D_ADDR) | (st_r == QP_D_INSTR) | (st_r == QP_D_DATA);
	wire byte_done = scl_fall & ~bus_cond & rx_state & (cnt_r == 4'd8);
	wire ack_done  = scl_fall & ~bus_cond & rx_state & (cnt_r == 4'd9);
	wire addr_hit  = (sh_r[7:4] == TYPE_CODE) & (sh_r[3:0] == strap_q) & ~busy_r;
	// instruction fields, valid while the instruction byte completes
	wire [3:0] new_op   = sh_r[7:4];
	wire [1:0] new_psel = sh_r[3:2];
	wire [1:0] new_pot  = sh_r[1:0];
	wire instr_done = byte_done & (st_r == QP_D_INSTR);
	wire data_done  = byte_done & (st_r == QP_D_DATA);
	wire op_p2w     = (new_op == `QP_OP_XFR_P2W) | (new_op == `QP_OP_GANG_P2W);
	wire op_w2p     = (new_op == `QP_OP_XFR_W2P) | (new_op == `QP_OP_GANG_W2P);
	wire op_gang    = (new_op == `QP_OP_GANG_P2W) | (new_op == `QP_OP_GANG_W2P);
	wire op_rd      = (new_op == `QP_OP_RD_WIPER) | (new_op == `QP_OP_RD_PRESET);
	wire op_wr      = (new_op == `QP_OP_WR_WIPER) | (new_op == `QP_OP_WR_PRESET);
	wire do_p2w     = instr_done & op_p2w;
	wire do_wr_wip  = data_done & (op_r == `QP_OP_WR_WIPER);
	wire data_ack   = (op_r == `QP_OP_WR_WIPER) | ((op_r == `QP_OP_WR_PRESET) & wp_q);
	// step on the falling edge: the stop's own high pulse never completes, so it never moves the wiper
	wire step       = scl_fall & ~bus_cond & (st_r == QP_D_INCDEC);
	wire prog_done  = busy_r & (prog_cnt_r == CW'(1));
	wire [7:0] rd_val = {2'b00, (op_r == `QP_OP_RD_WIPER) ? wiper_r[pot_r] : preset_r[pot_r][psel_r]};
	qp_dev_st_e nst_instr;
	assign nst_instr = op_rd ? QP_D_READ : op_wr ? QP_D_DATA
		: (new_op == `QP_OP_INCDEC) ? QP_D_INCDEC : QP_D_IDLE;

	assign bus.dev_sda_oe     = drv_r & ~busy_r;
	assign wiper_position_reg = wiper_r;
	assign nv_busy            = busy_r;

	always_ff @(posedge mclk) begin
		if (rst) begin
			scl_m <= 1'b1; scl_q <= 1'b1; scl_p <= 1'b1;
			sda_m <= 1'b1; sda_q <= 1'b1; sda_p <= 1'b1;
			strap_m <= 4'h0; strap_q <= 4'h0; wp_m <= 1'b0; wp_q <= 1'b0;
		end else begin
			scl_m <= bus.scl; scl_q <= scl_m; scl_p <= scl_q;
			sda_m <= bus.sda; sda_q <= sda_m; sda_p <= sda_q;
			strap_m <= address_strap_pins; strap_q <= strap_m;
			wp_m <= wp_n; wp_q <= wp_m;
		end
	end

	// serial sequencer
	always_ff @(posedge mclk) begin
		if (rst) begin
			st_r <= QP_D_IDLE; cnt_r <= 4'd0; sh_r <= 8'h00; tx_r <= 8'h00; drv_r <= 1'b0; mack_r <= 1'b0;
			op_r <= 4'h0; psel_r <= 2'd0; pot_r <= 2'd0;
		end else if (start_det) begin
			st_r <= QP_D_ADDR;
			cnt_r <= 4'd0;
			drv_r <= 1'b0;
		end else if (stop_det) begin
			st_r <= QP_D_IDLE;
			cnt_r <= 4'd0;
			drv_r <= 1'b0;
		end else if (scl_rise && st_r != QP_D_IDLE && st_r != QP_D_INCDEC) begin
			if (cnt_r < 4'd8 && st_r != QP_D_READ)
				sh_r <= {sh_r[6:0], sda_q};
			if (cnt_r == 4'd8 && st_r == QP_D_READ)
				mack_r <= ~sda_q;
			cnt_r <= cnt_r + 4'd1;
		end else if (scl_fall && st_r == QP_D_READ) begin
			if (cnt_r < 4'd8)
				drv_r <= ~tx_r[3'(4'd7 - cnt_r)];
			else if (cnt_r == 4'd8)
				drv_r <= 1'b0;
			else if (mack_r) begin
				cnt_r <= 4'd0;
				tx_r <= rd_val;
				drv_r <= ~rd_val[7];
			end else
				st_r <= QP_D_IDLE;
		end else if (byte_done) begin
			unique case (st_r)
				QP_D_ADDR: begin
					drv_r <= addr_hit;
					if (!addr_hit)
						st_r <= QP_D_IDLE;
				end
				QP_D_INSTR: begin
					drv_r <= 1'b1;
					op_r <= new_op;
					psel_r <= new_psel;
					pot_r <= new_pot;
				end
				default: begin
					drv_r <= data_ack;
					if (!data_ack)
						st_r <= QP_D_IDLE;
				end
			endcase
		end else if (ack_done) begin
			drv_r <= 1'b0;
			cnt_r <= 4'd0;
			unique case (st_r)
				QP_D_ADDR:  st_r <= QP_D_INSTR;
				QP_D_INSTR: st_r <= nst_instr;
				default:    st_r <= QP_D_IDLE;
			endcase
			if (st_r == QP_D_INSTR && nst_instr == QP_D_READ) begin
				tx_r <= rd_val;
				drv_r <= ~rd_val[7];
			end
		end
	end

	// deferred non-volatile write, launched only by the closing STOP
	always_ff @(posedge mclk) begin
		if (rst) begin
			pend_r <= 1'b0; pend_wip_r <= 1'b0; pend_gang_r <= 1'b0; pend_sel_r <= 2'd0; pend_pot_r <= 2'd0;
			pend_val_r <= 6'h00; busy_r <= 1'b0; prog_cnt_r <= '0;
		end else begin
			if (busy_r)
				prog_cnt_r <= prog_cnt_r - CW'(1);
			if (prog_done)
				busy_r <= 1'b0;
			if (start_det)
				pend_r <= 1'b0;
			else if (stop_det) begin
				pend_r <= 1'b0;
				if (pend_r && wp_q && !busy_r) begin
					busy_r <= 1'b1;
					prog_cnt_r <= CW'(NV_PROG_CYC);
				end
			end else if (instr_done && op_w2p) begin
				pend_r <= 1'b1;
				pend_wip_r <= 1'b1;
				pend_gang_r <= op_gang;
				pend_sel_r <= new_psel;
				pend_pot_r <= new_pot;
			end else if (data_done && op_r == `QP_OP_WR_PRESET && wp_q) begin
				pend_r <= 1'b1;
				pend_wip_r <= 1'b0;
				pend_gang_r <= 1'b0;
				pend_sel_r <= psel_r;
				pend_pot_r <= pot_r;
				pend_val_r <= sh_r[5:0];
			end
		end
	end

	always_ff @(posedge mclk) begin
		boot_r <= rst;
	end

	genvar p;
	generate
		for (p = 0; p < 4; p++) begin : g_pot
			always_ff @(posedge mclk) begin
				if (rst)
					wiper_r[p] <= 6'h00;
				else if (boot_r)
					wiper_r[p] <= preset_r[p][0];
				else if (do_p2w && (op_gang || new_pot == 2'(p)))
					wiper_r[p] <= preset_r[p][new_psel];
				else if (do_wr_wip && pot_r == 2'(p))
					wiper_r[p] <= sh_r[5:0];
				else if (step && pot_r == 2'(p)) begin
					if (sda_q && wiper_r[p] != `QP_WIPER_MAX)
						wiper_r[p] <= wiper_r[p] + 6'h01;
					else if (!sda_q && wiper_r[p] != 6'h00)
						wiper_r[p] <= wiper_r[p] - 6'h01;
				end
			end
			always_ff @(posedge mclk) begin
				if (rst)
					preset_r[p] <= {4{`QP_PRESET_INIT}};
				else if (prog_done && (pend_gang_r || pend_pot_r == 2'(p)))
					preset_r[p][pend_sel_r] <= pend_wip_r ? wiper_r[p] : pend_val_r;
			end
			assign tap_sel[p] = 64'h0000_0000_0000_0001 << wiper_r[p];
		end
	endgenerate
endmodule : qp_dev
`default_nettype wire

// *** testbench/qp_chk.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "qp_map.svh"
module qp_chk #(
	parameter logic [3:0] TYPE_CODE   = 4'hA, // arbitrary device-type code
	parameter int         NV_PROG_CYC = 2000
) (
	input wire logic                    mclk,
	input wire logic                    rst,
	input wire logic                    scl,
	input wire logic                    host_sda_oe,
	input wire logic                    dev_sda_oe,
	input wire logic                    sda,
	input wire logic [3:0]              address_strap_pins,
	input wire logic                    wp_n,
	input wire qp_pkg::qp_wiper_t [3:0] wiper_position_reg,
	input wire logic [3:0][63:0]        tap_sel,
	input wire logic                    nv_busy
);
	import qp_pkg::*;
	logic       scl_q;
	logic       sda_q;
	logic       idle_r;
	logic       sel_r;
	logic       tap_ok;
	logic [3:0] bitn_r;
	logic [1:0] byten_r;
	logic [7:0] sh_r;
	logic [7:0] ins_r;
	int         busy_cnt_r;
	// line edges seen on the raw wires, ahead of the device's synchronisers
	wire        rise     = scl & ~scl_q;
	wire        start    = scl & scl_q & sda_q & ~sda;
	wire        stop     = scl & scl_q & ~sda_q & sda;
	wire        ninth    = rise & (bitn_r == 4'h8);
	wire        addr_hit = (sh_r == {TYPE_CODE, address_strap_pins}) & ~nv_busy;
	wire [3:0]  op       = ins_r[7:4];
	wire        is_read  = (op == `QP_OP_RD_WIPER) | (op == `QP_OP_RD_PRESET);
	wire        is_wr    = (op == `QP_OP_WR_WIPER) | ((op == `QP_OP_WR_PRESET) & wp_n);
	wire        wp_block = (op == `QP_OP_WR_PRESET) & ~wp_n;
	always_comb begin
		tap_ok = 1'b1;
		for (int p = 0; p < 4; p++)
			tap_ok &= (tap_sel[p] == (64'h1 << wiper_position_reg[p]));
	end
	always_ff @(posedge mclk) begin
		scl_q <= rst | scl;
		sda_q <= rst | sda;
		idle_r <= rst | stop | (idle_r & ~start);
	end
	always_ff @(posedge mclk) begin
		if (rst || start || stop) begin
			bitn_r  <= 4'h0;
			byten_r <= 2'h0;
		end else if (rise) begin
			bitn_r  <= ninth ? 4'h0 : bitn_r + 4'h1;
			byten_r <= (ninth && byten_r != 2'h3) ? byten_r + 2'h1 : byten_r;
		end
	end
	always_ff @(posedge mclk) begin
		sh_r  <= rst ? 8'h00 : ((rise && !ninth) ? {sh_r[6:0], sda} : sh_r);
		sel_r <= rst ? 1'b0 : ((ninth && byten_r == 2'h0) ? addr_hit : sel_r);
		ins_r <= rst ? 8'h00 : ((ninth && byten_r == 2'h1) ? sh_r : ins_r);
	end
	always_ff @(posedge mclk)
		busy_cnt_r <= (rst || !nv_busy) ? 0 : busy_cnt_r + 1;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	property p_busy_quiet; nv_busy |-> !dev_sda_oe; endproperty
	a_busy_quiet: assert property (p_busy_quiet) else $error("device drove sda while programming");
	property p_busy_len; busy_cnt_r <= NV_PROG_CYC; endproperty
	a_busy_len: assert property (p_busy_len) else $error("programming ran too long");
	property p_busy_at_stop; $rose(nv_busy) |-> idle_r; endproperty
	a_busy_at_stop: assert property (p_busy_at_stop) else $error("programming began outside a stop");
	property p_held_high; scl && $past(scl) |-> $stable(dev_sda_oe); endproperty
	a_held_high: assert property (p_held_high) else $error("device changed sda while scl high");
	property p_idle_quiet; idle_r |-> !dev_sda_oe; endproperty
	a_idle_quiet: assert property (p_idle_quiet) else $error("device drove sda before a start");
	property p_host_gap; ninth && byten_r < 2'h2 |-> !host_sda_oe; endproperty
	a_host_gap: assert property (p_host_gap) else $error("host held sda in acknowledge slot");
	property p_addr_ack; ninth && byten_r == 2'h0 |-> dev_sda_oe == addr_hit; endproperty
	a_addr_ack: assert property (p_addr_ack) else $error("address acknowledge wrong");
	property p_instr_ack; ninth && byten_r == 2'h1 && sel_r |-> dev_sda_oe; endproperty
	a_instr_ack: assert property (p_instr_ack) else $error("instruction not acknowledged");
	property p_data_ack; ninth && byten_r == 2'h2 && sel_r && is_wr |-> dev_sda_oe; endproperty
	a_data_ack: assert property (p_data_ack) else $error("data byte not acknowledged");
	property p_wp_nack; ninth && byten_r == 2'h2 && sel_r && wp_block |-> !dev_sda_oe; endproperty
	a_wp_nack: assert property (p_wp_nack) else $error("protected data acknowledged");
	property p_read_rel; ninth && byten_r == 2'h2 && sel_r && is_read |-> !dev_sda_oe; endproperty
	a_read_rel: assert property (p_read_rel) else $error("device kept sda after read byte");
	property p_tap; tap_ok; endproperty
	a_tap: assert property (p_tap) else $error("tap selection not one-hot of wiper");
endmodule : qp_chk
`default_nettype wire

// *** testbench/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "qp_map.svh"
module tb_top;
	import qp_pkg::*;
	localparam int         NV_CYC = 2000;
	localparam logic [3:0] TYPE   = 4'hA; // arbitrary device-type code
	typedef struct {logic ack; logic chk_rd; logic [7:0] rd; logic chk_w; logic [1:0] pot; logic [5:0] w;} qp_note_s;
	logic             mclk;
	logic             rst;
	logic             req;
	logic             rd_mode;
	logic             step_up;
	logic             wp_n;
	logic             ready;
	logic             done;
	logic             acked;
	logic             nv_busy;
	logic [7:0]       addr_byte;
	logic [7:0]       instr_byte;
	logic [7:0]       wr_byte;
	logic [7:0]       rd_byte;
	logic [7:0]       adr;
	logic [1:0]       nbytes;
	logic [5:0]       step_cnt;
	logic [3:0]       strap;
	logic [5:0]       w[4];
	logic [5:0]       v[4];
	qp_wiper_t [3:0]  wiper;
	logic [3:0][63:0] tap_sel;
	logic [31:0]      lfsr = 32'h0000_1c80;
	qp_note_s         notes[$];
	qp_note_s         nt;
	int               miscompares;
	int               num_checks;
	qp_if bus_if();
	qp_host #(.PWRUP_CYC(200), .QTR_CYC(8)) qp_host_i (.mclk, .rst, .bus(bus_if), .req, .addr_byte, .instr_byte,
		.wr_byte, .nbytes, .rd_mode, .step_cnt, .step_up, .ready, .done, .acked, .rd_byte);
	qp_dev #(.TYPE_CODE(TYPE), .NV_PROG_CYC(NV_CYC)) qp_dev_i (.mclk, .rst, .bus(bus_if),
		.address_strap_pins(strap), .wp_n, .wiper_position_reg(wiper), .tap_sel, .nv_busy);
	qp_chk #(.TYPE_CODE(TYPE), .NV_PROG_CYC(NV_CYC)) qp_chk_i (.mclk, .rst, .scl(bus_if.scl),
		.host_sda_oe(bus_if.host_sda_oe), .dev_sda_oe(bus_if.dev_sda_oe), .sda(bus_if.sda),
		.address_strap_pins(strap), .wp_n, .wiper_position_reg(wiper), .tap_sel, .nv_busy);
	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr_next
	task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
		num_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask : chk
	task automatic conclude();
		if (miscompares == 0 && num_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : conclude
	// one whole frame; the expected outcome is queued before the request goes out
	task automatic xfer(input logic [7:0] a, input logic [1:0] nb, input logic [7:0] ins, input logic [7:0] dat,
			input logic rd, input logic [5:0] steps, input logic up, input logic ack, input logic [7:0] exp_rd,
			input logic chk_w, input logic [5:0] exp_w);
		int n;
		notes.push_back('{ack, rd, exp_rd, chk_w, ins[1:0], exp_w});
		n = 0;
		@(posedge mclk);
		#1;
		while (ready !== 1'b1 && n < 5000) begin
			@(posedge mclk);
			#1;
			n++;
		end
		addr_byte = a;
		nbytes = nb;
		instr_byte = ins;
		wr_byte = dat;
		rd_mode = rd;
		step_cnt = steps;
		step_up = up;
		req = 1'b1;
		@(posedge mclk);
		#1;
		req = 1'b0;
		n = 0;
		while (done !== 1'b1 && n < 20000) begin
			@(negedge mclk);
			n++;
		end
		if (done !== 1'b1)
			miscompares++;
	endtask : xfer
	task automatic wait_idle();
		int n;
		n = 0;
		while (nv_busy !== 1'b0 && n < 3 * NV_CYC) begin
			@(negedge mclk);
			n++;
		end
		chk("nv_busy", 64'h0, nv_busy);
	endtask : wait_idle
	always @(negedge mclk) begin
		if (done === 1'b1) begin
			nt = notes.pop_front();
			chk("acked", nt.ack, acked);
			if (nt.chk_rd)
				chk("rd_byte", nt.rd, rd_byte);
			if (nt.chk_w)
				chk("wiper", nt.w, wiper[nt.pot]);
		end
	end
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	initial begin
		#1000000;
		miscompares++;
		conclude();
	end
	initial begin
		rst = 1'b1;
		req = 1'b0;
		rd_mode = 1'b0;
		step_up = 1'b0;
		wp_n = 1'b1;
		addr_byte = 8'h00;
		instr_byte = 8'h00;
		wr_byte = 8'h00;
		nbytes = 2'h0;
		step_cnt = 6'h00;
		lfsr = lfsr_next(lfsr);
		// low lfsr bits stay zero for the first draws, so values come from higher up
		strap = lfsr[13:10];
		adr = {TYPE, lfsr[13:10]};
		repeat (10) @(posedge mclk);
		#1;
		rst = 1'b0;
		repeat (100) @(posedge mclk);
		#1;
		chk("ready", 64'h0, ready);
		for (int p = 0; p < 4; p++) begin
			chk("wiper", `QP_PRESET_INIT, wiper[p]);
			chk("tap_sel", 64'h1 << `QP_PRESET_INIT, tap_sel[p]);
		end
		xfer({TYPE, ~strap}, 2'h1, 8'h00, 8'h00, 0, 0, 0, 0, 0, 0, 0);
		xfer({4'h3, strap}, 2'h1, 8'h00, 8'h00, 0, 0, 0, 0, 0, 0, 0);
		for (int p = 0; p < 4; p++) begin
			lfsr = lfsr_next(lfsr);
			w[p] = lfsr[15:10];
			xfer(adr, 2'h3, {`QP_OP_WR_WIPER, 2'h0, 2'(p)}, {2'h0, w[p]}, 0, 0, 0, 1, 0, 1, w[p]);
		end
		xfer(adr, 2'h3, {`QP_OP_RD_WIPER, 4'h2}, 8'h00, 1, 0, 0, 1, {2'h0, w[2]}, 0, 0);
		for (int r = 0; r < 4; r++) begin
			lfsr = lfsr_next(lfsr);
			v[r] = lfsr[15:10];
			xfer(adr, 2'h3, {`QP_OP_WR_PRESET, 2'(r), 2'h1}, {2'h0, v[r]}, 0, 0, 0, 1, 0, 0, 0);
			if (r == 3) begin
				@(posedge mclk);
				#1;
				wp_n = 1'b0;
			end
			xfer(adr, 2'h1, 8'h00, 8'h00, 0, 0, 0, 0, 0, 0, 0);
			wait_idle();
			xfer(adr, 2'h1, 8'h00, 8'h00, 0, 0, 0, 1, 0, 0, 0);
		end
		for (int r = 0; r < 4; r++)
			xfer(adr, 2'h3, {`QP_OP_RD_PRESET, 2'(r), 2'h1}, 8'h00, 1, 0, 0, 1, {2'h0, v[r]}, 0, 0);
		// protect still low: data refused and nothing programmed
		xfer(adr, 2'h3, {`QP_OP_WR_PRESET, 4'h1}, {2'h0, ~v[0]}, 0, 0, 0, 0, 0, 0, 0);
		repeat (20) @(negedge mclk);
		chk("nv_busy", 64'h0, nv_busy);
		xfer(adr, 2'h3, {`QP_OP_RD_PRESET, 4'h1}, 8'h00, 1, 0, 0, 1, {2'h0, v[0]}, 0, 0);
		@(posedge mclk);
		#1;
		wp_n = 1'b1;
		xfer(adr, 2'h2, {`QP_OP_XFR_P2W, 4'h9}, 8'h00, 0, 0, 0, 1, 0, 1, v[2]);
		xfer(adr, 2'h3, {`QP_OP_WR_WIPER, 4'h3}, 8'h3e, 0, 0, 0, 1, 0, 1, 6'h3e);
		xfer(adr, 2'h2, {`QP_OP_INCDEC, 4'h3}, 8'h00, 0, 6'h05, 1, 1, 0, 1, `QP_WIPER_MAX);
		xfer(adr, 2'h2, {`QP_OP_INCDEC, 4'h3}, 8'h00, 0, 6'h03, 0, 1, 0, 1, 6'h3c);
		xfer(adr, 2'h2, {`QP_OP_XFR_W2P, 4'h3}, 8'h00, 0, 0, 0, 1, 0, 0, 0);
		wait_idle();
		xfer(adr, 2'h3, {`QP_OP_RD_PRESET, 4'h3}, 8'h00, 1, 0, 0, 1, 8'h3c, 0, 0);
		xfer(adr, 2'h2, {`QP_OP_GANG_P2W, 4'h0}, 8'h00, 0, 0, 0, 1, 0, 1, `QP_PRESET_INIT);
		repeat (5) @(negedge mclk);
		conclude();
	end
endmodule : tb_top
`default_nettype wire
